// *** include/ssr_pkg.sv ***
package ssr_pkg;

  // Sizes of the register sets.
  localparam int NUM_SETS = 11;
  localparam int REG_W = 16;
  localparam int STORE_W = 15;
  localparam int STD_W = 8;
  localparam int INT_W = 16;
  localparam int FRAC_W = 8;
  localparam int SET_IDX_W = 4;

  // Target indices on the command port.
  localparam logic [3:0] SET_DEVICE = 4'h0;
  localparam logic [3:0] SET_OPER = 4'h1;
  localparam logic [3:0] SET_OPER_CAL = 4'h2;
  localparam logic [3:0] SET_OPER_LLF = 4'h3;
  localparam logic [3:0] SET_OPER_MEAS = 4'h4;
  localparam logic [3:0] SET_OPER_SENS = 4'h5;
  localparam logic [3:0] SET_OPER_TRIG = 4'h6;
  localparam logic [3:0] SET_OPER_ULF = 4'h7;
  localparam logic [3:0] SET_QUES = 4'h8;
  localparam logic [3:0] SET_QUES_CAL = 4'h9;
  localparam logic [3:0] SET_QUES_POW = 4'hA;
  localparam logic [3:0] SET_STD_EVENT = 4'hB;
  localparam logic [3:0] SET_STATUS_BYTE = 4'hC;
  localparam logic [3:0] SET_QUEUE = 4'hD;

  // Summary bit positions inside parent condition registers.
  localparam int OPER_CAL_BIT = 0;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_SENS_BIT = 10;
  localparam int OPER_LLF_BIT = 11;
  localparam int OPER_ULF_BIT = 12;
  localparam int QUES_POW_BIT = 3;
  localparam int QUES_CAL_BIT = 8;

  // Status byte bit positions.
  localparam int STB_QUES_BIT = 3;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;

  // Preset and power-on values.
  localparam logic [14:0] ENABLE_PRESET = 15'h0000;
  localparam logic [14:0] NTR_PRESET = 15'h0000;
  localparam logic [14:0] PTR_PRESET = 15'h7FFF;
  localparam logic [14:0] QUEUE_EN_PRESET = 15'h0000;
  localparam logic [14:0] EVENT_RESET = 15'h0000;
  localparam logic [14:0] COND_RESET = 15'h0000;
  localparam logic [7:0] STD_RESET = 8'h00;

  // Sub-register selector carried with each access.
  typedef enum logic [2:0] {
    SSR_SUB_EVENT,
    SSR_SUB_COND,
    SSR_SUB_ENABLE,
    SSR_SUB_NTR,
    SSR_SUB_PTR
  } ssr_sub_t;

endpackage

// *** hdl/ssr_round.sv ***
`timescale 1ns/10ps
module ssr_round (
  // Fixed-point parameter in.
  input wire logic [ssr_pkg::INT_W+ssr_pkg::FRAC_W-1:0] value_i,
  // Rounded value, lower bits only.
  output logic [ssr_pkg::STORE_W-1:0] stored_o
);

  logic [ssr_pkg::INT_W:0] rounded;

  // Rounds half up, then keeps only the lower storable bits.
  always_comb begin
    rounded = {1'b0, value_i[ssr_pkg::INT_W+ssr_pkg::FRAC_W-1:ssr_pkg::FRAC_W]}
              + {{ssr_pkg::INT_W{1'b0}}, value_i[ssr_pkg::FRAC_W-1]}; // RULE_06
    stored_o = rounded[ssr_pkg::STORE_W-1:0]; // RULE_05
  end

endmodule

// *** hdl/ssr_set.sv ***
`timescale 1ns/10ps
module ssr_set (
  // Clock and power-on reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Condition levels and control.
  input wire logic [14:0] cond_i,
  input wire logic wr_en_i,
  input wire ssr_pkg::ssr_sub_t wr_sub_i,
  input wire logic [14:0] wr_data_i,
  input wire logic ev_rd_clr_i,
  input wire logic cls_i,
  input wire logic preset_i,
  // Register contents.
  output logic [14:0] cond_o,
  output logic [14:0] event_o,
  output logic [14:0] enable_o,
  output logic [14:0] ntr_o,
  output logic [14:0] ptr_o,
  output logic summary_o
);

  logic [14:0] cond_q, cond_d, event_q, event_d, enable_q, enable_d;
  logic [14:0] ntr_q, ntr_d, ptr_q, ptr_d, rise_hit, fall_hit;

  // Transition detection and next register values.
  always_comb begin
    rise_hit = cond_i & ~cond_q & ptr_q; // RULE_13
    fall_hit = ~cond_i & cond_q & ntr_q; // RULE_13
    cond_d = cond_i;
    // A read or a clear empties the register, but a new transition still lands.
    event_d = ((ev_rd_clr_i || cls_i) ? ssr_pkg::EVENT_RESET : event_q)
              | rise_hit | fall_hit; // RULE_03 RULE_11
    enable_d = enable_q;
    ntr_d = ntr_q;
    ptr_d = ptr_q;
    if (preset_i) begin
      enable_d = ssr_pkg::ENABLE_PRESET; // RULE_10
      ntr_d = ssr_pkg::NTR_PRESET;
      ptr_d = ssr_pkg::PTR_PRESET;
    end else if (wr_en_i) begin
      case (wr_sub_i)
        ssr_pkg::SSR_SUB_ENABLE: enable_d = wr_data_i; // RULE_05
        ssr_pkg::SSR_SUB_NTR: ntr_d = wr_data_i; // RULE_08
        ssr_pkg::SSR_SUB_PTR: ptr_d = wr_data_i; // RULE_09
        default: enable_d = enable_q;
      endcase
    end
  end

  // Register stage; power on presets filters and clears events.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cond_q <= ssr_pkg::COND_RESET;
      event_q <= ssr_pkg::EVENT_RESET;
      enable_q <= ssr_pkg::ENABLE_PRESET;
      ntr_q <= ssr_pkg::NTR_PRESET;
      ptr_q <= ssr_pkg::PTR_PRESET;
    end else begin
      cond_q <= cond_d;
      event_q <= event_d;
      enable_q <= enable_d;
      ntr_q <= ntr_d;
      ptr_q <= ptr_d;
    end
  end

  // Outputs; bit 15 is added as zero by the reader.
  assign cond_o = cond_q;
  assign event_o = event_q;
  assign enable_o = enable_q;
  assign ntr_o = ntr_q;
  assign ptr_o = ptr_q;
  assign summary_o = |(event_q & enable_q); // RULE_14

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_quiet_read;
    ev_rd_clr_i && (rise_hit == 15'h0000) && (fall_hit == 15'h0000);
  endsequence

  sequence s_quiet_cls;
    cls_i && (rise_hit == 15'h0000) && (fall_hit == 15'h0000);
  endsequence

  AST_READ_CLEARS: assert property (s_quiet_read |=> event_q == 15'h0000) // RULE_03
    else $error("Event register not cleared by read.");
  AST_CLS_CLEARS: assert property (s_quiet_cls |=> event_q == 15'h0000) // RULE_11
    else $error("Event register not cleared by clear status.");
  AST_RISE_SETS: assert property (
    (rise_hit != 15'h0000) |=> ((event_q & $past(rise_hit)) == $past(rise_hit))) // RULE_13
    else $error("Rising transition did not set event bit.");
  AST_FALL_SETS: assert property (
    (fall_hit != 15'h0000) |=> ((event_q & $past(fall_hit)) == $past(fall_hit))) // RULE_13
    else $error("Falling transition did not set event bit.");
  AST_ENABLE_WRITE: assert property (
    (wr_en_i && !preset_i && wr_sub_i == ssr_pkg::SSR_SUB_ENABLE)
    |=> enable_q == $past(wr_data_i)) // RULE_05
    else $error("Enable write not stored.");
  AST_NTR_WRITE: assert property (
    (wr_en_i && !preset_i && wr_sub_i == ssr_pkg::SSR_SUB_NTR)
    |=> ntr_q == $past(wr_data_i)) // RULE_08
    else $error("Falling filter write not stored.");
  AST_PTR_WRITE: assert property (
    (wr_en_i && !preset_i && wr_sub_i == ssr_pkg::SSR_SUB_PTR)
    |=> ptr_q == $past(wr_data_i)) // RULE_09
    else $error("Rising filter write not stored.");
  AST_PRESET: assert property (preset_i |=> (ptr_q == ssr_pkg::PTR_PRESET)
    && (ntr_q == ssr_pkg::NTR_PRESET) && (enable_q == ssr_pkg::ENABLE_PRESET)) // RULE_10
    else $error("Preset did not load filters and enable.");
  AST_CLS_KEEPS: assert property ((cls_i && !preset_i && !wr_en_i)
    |=> $stable(enable_q) && $stable(ntr_q) && $stable(ptr_q)) // RULE_10
    else $error("Clear status disturbed filters or enable.");

endmodule

// *** hdl/ssr_top.sv ***
`timescale 1ns/10ps
// Function
// RULE_01 - Eleven register sets, each with condition, event, enable and two filters.
// RULE_02 - Condition read returns 15 bits, bit 15 zero, contents unchanged.
// RULE_03 - Event read returns contents then clears the event register.
// RULE_04 - Access with no sub-register selector is an event read with clear.
// RULE_05 - Enable write stores lower 15 bits of rounded value, bit 15 zero.
// RULE_06 - Host sends 0 to 65535; device rounds to integer before storing.
// RULE_07 - Enable read returns the stored 15-bit value.
// RULE_08 - Falling filter stores lower 15 bits; read returns 15 bits.
// RULE_09 - Rising filter stores lower 15 bits, bit 15 held zero.
// RULE_10 - Filters, enables, queue enable: preset at power on and preset command only.
// RULE_11 - Event registers and queue cleared by clear status and power on.
// RULE_12 - Standard event and status byte cleared by clear status; their enables only at power on.
// RULE_13 - Filter bit one sets event bit on the selected condition transition.
// RULE_14 - Each set's enabled events OR into one summary bit of its parent. The SET_DEVICE summary drives no parent bit.
module ssr_top (
  // Clock and power-on reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Parsed status command.
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [ssr_pkg::SET_IDX_W-1:0] cmd_set_i,
  input wire ssr_pkg::ssr_sub_t cmd_sub_i,
  input wire logic [ssr_pkg::INT_W+ssr_pkg::FRAC_W-1:0] cmd_wdata_i,
  // Common commands.
  input wire logic cls_i,
  input wire logic preset_i,
  // Condition pins and standard event pulses.
  input wire logic [ssr_pkg::NUM_SETS*ssr_pkg::STORE_W-1:0] cond_pin_i,
  input wire logic [ssr_pkg::STD_W-1:0] std_event_i,
  // Answers and summaries.
  output logic rsp_valid_o,
  output logic [ssr_pkg::REG_W-1:0] rsp_data_o,
  output logic [ssr_pkg::STD_W-1:0] status_byte_o,
  output logic queue_clear_o
);

  localparam int N = ssr_pkg::NUM_SETS;

  logic [N*15-1:0] sync1_q, sync2_q;
  logic [14:0] cond_in [N];
  logic [14:0] child [N];
  logic [14:0] cond_w [N];
  logic [14:0] event_w [N];
  logic [14:0] enable_w [N];
  logic [14:0] ntr_w [N];
  logic [14:0] ptr_w [N];
  logic [N-1:0] summary_w, wr_en, rd_clr;
  logic [14:0] wr_value;
  logic is_read, is_write;
  logic rsp_valid_q, rsp_valid_d, queue_clear_q, queue_clear_d;
  logic [15:0] rsp_data_q, rsp_data_d;
  logic [7:0] sesr_q, sesr_d, ese_q, ese_d, sre_q, sre_d, stb_q, stb_d, stb_bits;
  logic [14:0] queue_en_q, queue_en_d;

  // Two-flop synchroniser for the condition pins.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= cond_pin_i;
      sync2_q <= sync1_q;
    end
  end

  // Summary fan-in of child sets into their parents.
  always_comb begin
    for (int k = 0; k < N; k++) begin
      child[k] = 15'h0000;
    end
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_CAL_BIT] = summary_w[ssr_pkg::SET_OPER_CAL]; // RULE_14
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_LLF_BIT] = summary_w[ssr_pkg::SET_OPER_LLF];
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_MEAS_BIT] = summary_w[ssr_pkg::SET_OPER_MEAS];
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_SENS_BIT] = summary_w[ssr_pkg::SET_OPER_SENS];
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_TRIG_BIT] = summary_w[ssr_pkg::SET_OPER_TRIG];
    child[ssr_pkg::SET_OPER][ssr_pkg::OPER_ULF_BIT] = summary_w[ssr_pkg::SET_OPER_ULF];
    child[ssr_pkg::SET_QUES][ssr_pkg::QUES_CAL_BIT] = summary_w[ssr_pkg::SET_QUES_CAL];
    child[ssr_pkg::SET_QUES][ssr_pkg::QUES_POW_BIT] = summary_w[ssr_pkg::SET_QUES_POW];
  end

  // Access decode; condition and event are query only.
  assign is_read = cmd_valid_i && !cmd_write_i;
  assign is_write = cmd_valid_i && cmd_write_i;

  // Rounds the written parameter before any register takes it.
  ssr_round u_round (
    .value_i(cmd_wdata_i),
    .stored_o(wr_value)
  );

  // One register set per status group.
  for (genvar g = 0; g < N; g++) begin : g_set
    assign cond_in[g] = sync2_q[g*15 +: 15] | child[g];
    assign wr_en[g] = is_write && (cmd_set_i == 4'(g)); // RULE_01
    assign rd_clr[g] = is_read && (cmd_set_i == 4'(g))
                       && (cmd_sub_i == ssr_pkg::SSR_SUB_EVENT); // RULE_04
    ssr_set u_set (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .cond_i(cond_in[g]),
      .wr_en_i(wr_en[g]),
      .wr_sub_i(cmd_sub_i),
      .wr_data_i(wr_value),
      .ev_rd_clr_i(rd_clr[g]),
      .cls_i(cls_i),
      .preset_i(preset_i),
      .cond_o(cond_w[g]),
      .event_o(event_w[g]),
      .enable_o(enable_w[g]),
      .ntr_o(ntr_w[g]),
      .ptr_o(ptr_w[g]),
      .summary_o(summary_w[g])
    );
  end

  // Standard event, status byte and queue enable next values.
  always_comb begin
    sesr_d = sesr_q;
    if (cls_i || (is_read && cmd_set_i == ssr_pkg::SET_STD_EVENT
        && cmd_sub_i == ssr_pkg::SSR_SUB_EVENT)) begin
      sesr_d = ssr_pkg::STD_RESET; // RULE_12
    end
    sesr_d = sesr_d | std_event_i;
    ese_d = ese_q;
    sre_d = sre_q;
    queue_en_d = queue_en_q;
    if (preset_i) begin
      queue_en_d = ssr_pkg::QUEUE_EN_PRESET; // RULE_10
    end else if (is_write && cmd_sub_i == ssr_pkg::SSR_SUB_ENABLE) begin
      if (cmd_set_i == ssr_pkg::SET_QUEUE) begin
        queue_en_d = wr_value;
      end
    end
    if (is_write && cmd_sub_i == ssr_pkg::SSR_SUB_ENABLE) begin
      if (cmd_set_i == ssr_pkg::SET_STD_EVENT) begin
        ese_d = wr_value[7:0]; // RULE_12
      end
      if (cmd_set_i == ssr_pkg::SET_STATUS_BYTE) begin
        sre_d = wr_value[7:0];
      end
    end
    stb_bits = 8'h00;
    stb_bits[ssr_pkg::STB_QUES_BIT] = summary_w[ssr_pkg::SET_QUES];
    stb_bits[ssr_pkg::STB_OPER_BIT] = summary_w[ssr_pkg::SET_OPER];
    stb_bits[ssr_pkg::STB_ESB_BIT] = |(sesr_q & ese_q);
    stb_bits[ssr_pkg::STB_MSS_BIT] = |(stb_bits & sre_q);
    stb_d = cls_i ? ssr_pkg::STD_RESET : stb_bits; // RULE_12
    queue_clear_d = cls_i; // RULE_11
  end

  // Answer to each access, registered one cycle after it.
  always_comb begin
    rsp_valid_d = cmd_valid_i;
    rsp_data_d = 16'h0000;
    if (is_read) begin
      if (cmd_set_i < ssr_pkg::SET_STD_EVENT) begin
        case (cmd_sub_i)
          ssr_pkg::SSR_SUB_COND: rsp_data_d = {1'b0, cond_w[cmd_set_i]}; // RULE_02
          ssr_pkg::SSR_SUB_ENABLE: rsp_data_d = {1'b0, enable_w[cmd_set_i]}; // RULE_07
          ssr_pkg::SSR_SUB_NTR: rsp_data_d = {1'b0, ntr_w[cmd_set_i]}; // RULE_08
          ssr_pkg::SSR_SUB_PTR: rsp_data_d = {1'b0, ptr_w[cmd_set_i]};
          default: rsp_data_d = {1'b0, event_w[cmd_set_i]}; // RULE_03 RULE_04
        endcase
      end else if (cmd_set_i == ssr_pkg::SET_STD_EVENT) begin
        rsp_data_d = (cmd_sub_i == ssr_pkg::SSR_SUB_ENABLE) ? {8'h00, ese_q} : {8'h00, sesr_q};
      end else if (cmd_set_i == ssr_pkg::SET_STATUS_BYTE) begin
        rsp_data_d = (cmd_sub_i == ssr_pkg::SSR_SUB_ENABLE) ? {8'h00, sre_q} : {8'h00, stb_q};
      end else if (cmd_set_i == ssr_pkg::SET_QUEUE) begin
        rsp_data_d = {1'b0, queue_en_q};
      end
    end
  end

  // Register stage; only power on clears the standard enables.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      sesr_q <= ssr_pkg::STD_RESET;
      ese_q <= ssr_pkg::STD_RESET;
      sre_q <= ssr_pkg::STD_RESET;
      stb_q <= ssr_pkg::STD_RESET;
      queue_en_q <= ssr_pkg::QUEUE_EN_PRESET;
      queue_clear_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      sesr_q <= sesr_d;
      ese_q <= ese_d;
      sre_q <= sre_d;
      stb_q <= stb_d;
      queue_en_q <= queue_en_d;
      queue_clear_q <= queue_clear_d;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;
  assign status_byte_o = stb_q;
  assign queue_clear_o = queue_clear_q;

  sequence s_cond_read;
    is_read && (cmd_set_i == ssr_pkg::SET_DEVICE) && (cmd_sub_i == ssr_pkg::SSR_SUB_COND);
  endsequence

  AST_RSP_NEXT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    cmd_valid_i |=> rsp_valid_o) // RULE_01
    else $error("Answer missing one cycle after access.");
  AST_BIT15_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    rsp_valid_o |-> !rsp_data_o[15]) // RULE_02
    else $error("Answer bit 15 not zero.");
  AST_COND_READ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_cond_read |=> rsp_data_o[14:0] == $past(cond_w[0])) // RULE_02
    else $error("Condition read returned wrong value.");
  AST_SESR_CLS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cls_i && std_event_i == 8'h00) |=> sesr_q == 8'h00 && stb_q == 8'h00) // RULE_12
    else $error("Clear status left standard event or status byte.");
  AST_ESE_KEEP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cls_i && !is_write) |=> $stable(ese_q) && $stable(sre_q)) // RULE_12
    else $error("Clear status changed standard enables.");
  AST_QUEUE_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    cls_i |=> queue_clear_o) // RULE_11
    else $error("Queue clear pulse missing.");

endmodule

// *** verification/ssr_host.sv ***
`timescale 1ns/10ps
// Remote host model that issues parsed status commands, one access at a time.
module ssr_host (
  // Clock.
  input wire logic core_clk_i,
  // Command port.
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [3:0] cmd_set_o,
  output ssr_pkg::ssr_sub_t cmd_sub_o,
  output logic [23:0] cmd_wdata_o,
  // Common commands.
  output logic cls_o,
  output logic preset_o
);
  // Idle values at time zero.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_set_o = 4'h0;
    cmd_sub_o = ssr_pkg::SSR_SUB_EVENT;
    cmd_wdata_o = 24'h000000;
    cls_o = 1'b0;
    preset_o = 1'b0;
  end

  // Raises one access after an edge and holds it until the taking edge.
  task automatic access(input logic wr, input logic [3:0] set, input ssr_pkg::ssr_sub_t sub,
                        input logic [23:0] wd);
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= wr;
    cmd_set_o <= set;
    cmd_sub_o <= sub;
    cmd_wdata_o <= wd;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~wr;
    cmd_wdata_o <= ~wd;
  endtask

  // Sends one clear-status or preset pulse.
  task automatic pulse(input logic is_cls);
    @(posedge core_clk_i);
    cls_o <= is_cls;
    preset_o <= !is_cls;
    @(posedge core_clk_i);
    cls_o <= 1'b0;
    preset_o <= 1'b0;
  endtask
endmodule

// *** verification/ssr_top_tb.sv ***
`timescale 1ns/10ps
// Self-checking bench for the status register sets.
module ssr_top_tb;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cmd_valid, cmd_write, cls, preset, rsp_valid_o, queue_clear_o;
  logic [3:0] cmd_set;
  ssr_pkg::ssr_sub_t cmd_sub;
  logic [23:0] cmd_wdata;
  logic [ssr_pkg::NUM_SETS*ssr_pkg::STORE_W-1:0] cond_pin_i = '0;
  logic [7:0] std_event_i = 8'h00;
  logic [15:0] rsp_data_o;
  logic [7:0] status_byte_o;
  logic [15:0] exp_q[$];
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // Clock at 125 MHz.
  always #4 core_clk_i = ~core_clk_i;

  // Host model and design.
  ssr_host i_host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_set_o(cmd_set), .cmd_sub_o(cmd_sub), .cmd_wdata_o(cmd_wdata), .cls_o(cls),
    .preset_o(preset));
  ssr_top i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_set_i(cmd_set), .cmd_sub_i(cmd_sub), .cmd_wdata_i(cmd_wdata),
    .cls_i(cls), .preset_i(preset), .cond_pin_i(cond_pin_i), .std_event_i(std_event_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .status_byte_o(status_byte_o),
    .queue_clear_o(queue_clear_o));

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read and write accesses, each noting its expected answer.
  task automatic rd(input logic [3:0] set, input ssr_pkg::ssr_sub_t sub, input logic [15:0] exp);
    i_host.access(1'b0, set, sub, 24'h000000);
    exp_q.push_back(exp);
  endtask
  task automatic wr(input logic [3:0] set, input ssr_pkg::ssr_sub_t sub, input logic [23:0] wd);
    i_host.access(1'b1, set, sub, wd);
    exp_q.push_back(16'h0000);
  endtask

  // Pin, pulse and wait helpers driven at the rising edge.
  task automatic set_pin(input int b, input logic v);
    @(posedge core_clk_i);
    cond_pin_i[b] <= v;
  endtask
  task automatic pulse_std();
    @(posedge core_clk_i);
    std_event_i <= 8'h01;
    @(posedge core_clk_i);
    std_event_i <= 8'h00;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Rounds half up and keeps the low 15 bits.
  function automatic logic [14:0] rnd(input logic [23:0] wd);
    logic [24:0] s;
    s = {1'b0, wd} + 25'h0000080;
    return s[22:8];
  endfunction

  // Takes the oldest note whenever an answer appears.
  always @(negedge core_clk_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected rsp_valid_o", 16'h0001, 16'h0000);
      end else begin
        check("rsp_data_o", rsp_data_o, exp_q.pop_front());
      end
    end
  end

  // Cuts a hang short.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // Main sequence.
  initial begin
    logic [23:0] wd;
    ssr_pkg::ssr_sub_t sub;
    void'($urandom(60529));
    idle(4);
    rst_b_i <= 1'b1;
    // Power-on contents of every set, then an unmapped target.
    for (int s = 0; s < ssr_pkg::NUM_SETS; s++) begin
      rd(4'(s), ssr_pkg::SSR_SUB_COND, 16'h0000);
      rd(4'(s), ssr_pkg::SSR_SUB_EVENT, 16'h0000);
      rd(4'(s), ssr_pkg::SSR_SUB_ENABLE, {1'b0, ssr_pkg::ENABLE_PRESET});
      rd(4'(s), ssr_pkg::SSR_SUB_NTR, {1'b0, ssr_pkg::NTR_PRESET});
      rd(4'(s), ssr_pkg::SSR_SUB_PTR, {1'b0, ssr_pkg::PTR_PRESET});
    end
    rd(4'hE, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    // Writes with fractions and the wrap value, read back at once.
    for (int s = 0; s < ssr_pkg::NUM_SETS; s++) begin
      for (int k = 0; k < 3; k++) begin
        wd = (s == 0) ? ((k == 0) ? 24'hFFFF80 : 24'h000180) : 24'($urandom);
        sub = ssr_pkg::ssr_sub_t'(k + 2);
        wr(4'(s), sub, wd);
        rd(4'(s), sub, {1'b0, rnd(wd)});
      end
    end
    wr(4'h0, ssr_pkg::SSR_SUB_COND, 24'h123400);
    rd(4'h0, ssr_pkg::SSR_SUB_COND, 16'h0000);
    // Rising and falling transitions on set 0 bit 1.
    wr(4'h0, ssr_pkg::SSR_SUB_PTR, 24'h000200);
    wr(4'h0, ssr_pkg::SSR_SUB_NTR, 24'h000000);
    set_pin(1, 1'b1);
    idle(6);
    rd(4'h0, ssr_pkg::SSR_SUB_COND, 16'h0002);
    rd(4'h0, ssr_pkg::SSR_SUB_COND, 16'h0002);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0002);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    wr(4'h0, ssr_pkg::SSR_SUB_PTR, 24'h000000);
    wr(4'h0, ssr_pkg::SSR_SUB_NTR, 24'h000200);
    set_pin(1, 1'b0);
    idle(6);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0002);
    set_pin(1, 1'b1);
    idle(6);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    // Clear status keeps enables and filters but empties events.
    wr(4'h0, ssr_pkg::SSR_SUB_ENABLE, 24'h123400);
    set_pin(1, 1'b0);
    idle(6);
    i_host.pulse(1'b1);
    @(negedge core_clk_i);
    check("queue_clear_o", {15'h0000, queue_clear_o}, 16'h0001);
    @(negedge core_clk_i);
    check("queue_clear_o", {15'h0000, queue_clear_o}, 16'h0000);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    rd(4'h0, ssr_pkg::SSR_SUB_ENABLE, 16'h1234);
    rd(4'h0, ssr_pkg::SSR_SUB_NTR, 16'h0002);
    // Preset restores enables and filters but keeps events.
    wr(4'h0, ssr_pkg::SSR_SUB_PTR, 24'h000200);
    set_pin(1, 1'b1);
    idle(6);
    i_host.pulse(1'b0);
    rd(4'h0, ssr_pkg::SSR_SUB_EVENT, 16'h0002);
    rd(4'h0, ssr_pkg::SSR_SUB_ENABLE, {1'b0, ssr_pkg::ENABLE_PRESET});
    rd(4'h0, ssr_pkg::SSR_SUB_NTR, {1'b0, ssr_pkg::NTR_PRESET});
    rd(4'h0, ssr_pkg::SSR_SUB_PTR, {1'b0, ssr_pkg::PTR_PRESET});
    // Summary chain from a child set to the status byte.
    wr(ssr_pkg::SET_OPER_CAL, ssr_pkg::SSR_SUB_ENABLE, 24'h000200);
    wr(ssr_pkg::SET_OPER, ssr_pkg::SSR_SUB_ENABLE, 24'h000100);
    idle(2);
    check("status_byte_o[7]", {15'h0000, status_byte_o[7]}, 16'h0000);
    set_pin(31, 1'b1);
    idle(10);
    check("status_byte_o[7]", {15'h0000, status_byte_o[7]}, 16'h0001);
    rd(ssr_pkg::SET_OPER, ssr_pkg::SSR_SUB_COND, 16'h0001);
    // Standard event register cleared by read and clear status, its enable kept.
    pulse_std();
    idle(2);
    rd(ssr_pkg::SET_STD_EVENT, ssr_pkg::SSR_SUB_EVENT, 16'h0001);
    rd(ssr_pkg::SET_STD_EVENT, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    wr(ssr_pkg::SET_STD_EVENT, ssr_pkg::SSR_SUB_ENABLE, 24'h00FF00);
    pulse_std();
    idle(2);
    i_host.pulse(1'b1);
    rd(ssr_pkg::SET_STD_EVENT, ssr_pkg::SSR_SUB_EVENT, 16'h0000);
    i_host.pulse(1'b0);
    rd(ssr_pkg::SET_STD_EVENT, ssr_pkg::SSR_SUB_ENABLE, 16'h00FF);
    idle(4);
    check("pending answers", 16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule
